// File: rtl/dcf_regs.vh
// constants for the 18-bit flagged fifo
// assumes one clock domain and plain ports, no register bus
`ifndef DCF_REGS_VH
`define DCF_REGS_VH
`define DCF_WIDTH 18
`define DCF_DEPTH 13'h0100
`define DCF_AW 8
`define DCF_CNTW 13
`define DCF_BUF_DEPTH 3'h4
`define DCF_BUF_AW 2
`define DCF_SYNC_BITS 5
`define DCF_SYNC_RST 5'h00
`define DCF_SETTLE 2'h2
`define DCF_SETTLE_RST 2'h0
`define DCF_CNT_RST 13'h0000
`define DCF_Q_RST 18'h00000
`define DCF_AE_OFF_RST 13'h0007
`define DCF_AF_OFF_RST 13'h0007
`define DCF_SYNC_POS 3'h4
`define DCF_CASC_POS 3'h3
`define DCF_FIRST_POS 3'h2
`define DCF_WIN_POS 3'h1
`define DCF_RIN_POS 3'h0
`endif

// File: rtl/dcf_fifo.v
// small fifo with registered read data, width and depth as parameters
// assumes depth is a power of two and aw its log2
`timescale 1ns/1ps
module dcf_fifo #(
  parameter W = 18,
  parameter D = 4,
  parameter AW = 2
) (
  input wire clk_sys,
  input wire rstn,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] cnt_reg;
  reg out_valid_reg;
  reg [W-1:0] out_data_reg;
  wire push;
  wire pop;
  wire [AW:0] depth_w;

  assign depth_w = D[AW:0];
  assign in_ready = (cnt_reg != depth_w);
  assign push = in_valid & in_ready;
  // refill output stage whenever it is free or being drained
  assign pop = (cnt_reg != {(AW+1){1'b0}}) & (~out_valid_reg | out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
      out_data_reg <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        out_data_reg <= mem[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// File: rtl/dcf_top.v
// 18-bit fifo with empty, full, half-full and almost flags, depth cascade
// assumes write and read ports share clk_sys; straps are asynchronous pins
// Behaviour
// - 18-bit words, depth a parameter; here fixed at 256 by DCF_DEPTH
// - store input word when write enabled
// - back-to-back writes, no idle cycle
// - read advances only when read enabled
// - works with shared or independent clocks; here both ports run on clk_sys
// - write and read same cycle, independent
// - flags decode one of five fill states
// - half-full pin carries cascade write token
// - empty flag changes only on read clock
// - full flag changes only on write clock
// - flags stable, glitch free between cycles; async-mode almost flags are combinational
// - sync select low registers almost flags
// - active-low enables, blocked when full/empty
// - empty and full flags active low
// - sync select high: almost flags asynchronous
`timescale 1ns/1ps
`include "dcf_regs.vh"
module dcf_top (
  input wire clk_sys,
  input wire rstn,
  input wire [`DCF_WIDTH-1:0] data_in,
  input wire write_enable_n,
  input wire read_enable_n,
  input wire output_enable_n,
  input wire [`DCF_CNTW-1:0] almost_empty_offset,
  input wire [`DCF_CNTW-1:0] almost_full_offset,
  input wire flag_sync_select,
  input wire depth_cascade_mode,
  input wire first_load_n,
  input wire cascade_write_in,
  input wire cascade_read_in,
  output wire [`DCF_WIDTH-1:0] data_out,
  output wire data_out_oe,
  output wire empty_flag_n,
  output wire full_flag_n,
  output wire almost_empty_flag_n,
  output wire almost_full_flag_n,
  output wire half_full_flag_n,
  output wire cascade_read_out
);
  // half_full_flag_n doubles as the cascade write output in cascade mode

  reg [1:0] settle_reg;
  reg win_d_reg;
  reg rin_d_reg;
  reg first_seen_reg;
  reg wr_token_reg;
  reg rd_token_reg;
  reg wxo_pulse_reg;
  reg rxo_pulse_reg;
  reg [`DCF_CNTW-1:0] count_reg;
  reg [`DCF_CNTW-1:0] count_next;
  reg [`DCF_WIDTH-1:0] q_reg;
  reg ae_sync_reg;
  reg af_sync_reg;

  wire [`DCF_SYNC_BITS-1:0] strap_raw;
  wire [`DCF_SYNC_BITS-1:0] strap_sync;
  wire straps_ok;
  wire sync_mode_async;
  wire casc_mode;
  wire first_dev;
  wire win_rise;
  wire rin_rise;
  wire store_in_ready;
  wire store_out_valid;
  wire [`DCF_WIDTH-1:0] store_out_data;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [`DCF_WIDTH-1:0] buf_out_data;
  wire wr_go;
  wire rd_go;
  wire ae_level;
  wire af_level;
  wire half_level;
  wire [`DCF_CNTW-1:0] depth_w;
  wire [`DCF_CNTW-1:0] half_w;

  function sel_bit;
    input [`DCF_SYNC_BITS-1:0] v;
    input [2:0] pos;
    begin
      sel_bit = v[pos];
    end
  endfunction

  // count compares shared by flags, tokens and cascade pulses
  function cnt_at_top;
    input [`DCF_CNTW-1:0] c;
    begin
      cnt_at_top = (c == `DCF_DEPTH);
    end
  endfunction

  function cnt_at_zero;
    input [`DCF_CNTW-1:0] c;
    begin
      cnt_at_zero = (c == {`DCF_CNTW{1'b0}});
    end
  endfunction

  function at_or_below;
    input [`DCF_CNTW-1:0] c;
    input [`DCF_CNTW-1:0] lim;
    begin
      at_or_below = (c <= lim);
    end
  endfunction

  // offsets above the depth wrap; the loader must keep them in range
  function near_top;
    input [`DCF_CNTW-1:0] c;
    input [`DCF_CNTW-1:0] off;
    begin
      near_top = (c >= (`DCF_DEPTH - off));
    end
  endfunction

  assign strap_raw = {flag_sync_select, depth_cascade_mode,
                      first_load_n, cascade_write_in,
                      cascade_read_in};

  genvar gi;
  generate
    for (gi = 0; gi < `DCF_SYNC_BITS; gi = gi + 1) begin : g_sync
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= strap_raw[gi];
          stage2_reg <= stage1_reg;
        end
      end
      assign strap_sync[gi] = stage2_reg;
    end
  endgenerate

  assign sync_mode_async = sel_bit(strap_sync, `DCF_SYNC_POS);
  assign casc_mode = sel_bit(strap_sync, `DCF_CASC_POS);
  assign first_dev = ~sel_bit(strap_sync, `DCF_FIRST_POS);
  assign win_rise = sel_bit(strap_sync, `DCF_WIN_POS) & ~win_d_reg;
  assign rin_rise = sel_bit(strap_sync, `DCF_RIN_POS) & ~rin_d_reg;

  // synced straps read reset zeros for two edges; no token before that
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      settle_reg <= `DCF_SETTLE_RST;
    end else if (settle_reg != `DCF_SETTLE) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end
  assign straps_ok = (settle_reg == `DCF_SETTLE);

  assign depth_w = `DCF_DEPTH;
  assign half_w = {1'b0, depth_w[`DCF_CNTW-1:1]};

  // write only when enabled low and not full
  // one word per cycle while held low
  assign wr_go = ~write_enable_n & store_in_ready &
                 ~cnt_at_top(count_reg) &
                 (~casc_mode | wr_token_reg);
  // read only when enabled low and not empty
  assign rd_go = ~read_enable_n & buf_out_valid &
                 (~casc_mode | rd_token_reg);

  dcf_fifo #(
    .W(`DCF_WIDTH),
    .D(`DCF_DEPTH),
    .AW(`DCF_AW)
  ) u_store (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(wr_go),
    .in_data(data_in),
    .in_ready(store_in_ready),
    .out_valid(store_out_valid),
    .out_data(store_out_data),
    .out_ready(buf_in_ready)
  );

  // prefetch stage; back-pressure reaches storage through buf_in_ready
  dcf_fifo #(
    .W(`DCF_WIDTH),
    .D(`DCF_BUF_DEPTH),
    .AW(`DCF_BUF_AW)
  ) u_buf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(store_out_valid),
    .in_data(store_out_data),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(rd_go)
  );

  always @* begin
    count_next = count_reg;
    if (wr_go & ~rd_go) begin
      count_next = count_reg + 13'h0001;
    end else if (rd_go & ~wr_go) begin
      count_next = count_reg - 13'h0001;
    end
  end

  assign ae_level = at_or_below(count_reg, almost_empty_offset);
  // async mode trades glitch freedom for zero flag latency
  assign af_level = near_top(count_reg, almost_full_offset);
  assign half_level = (count_reg > half_w);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_reg <= `DCF_CNT_RST;
      q_reg <= `DCF_Q_RST;
    end else begin
      count_reg <= count_next;
      // read data held until the next accepted read
      if (rd_go) begin
        q_reg <= buf_out_data;
      end
    end
  end

  // almost flags registered in sync mode
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ae_sync_reg <= 1'b1;
      af_sync_reg <= 1'b0;
    end else begin
      ae_sync_reg <= at_or_below(count_next, almost_empty_offset);
      af_sync_reg <= near_top(count_next, almost_full_offset);
    end
  end

  // history idles low like tied-off cascade pins: no false edge
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      win_d_reg <= 1'b0;
      rin_d_reg <= 1'b0;
    end else begin
      win_d_reg <= sel_bit(strap_sync, `DCF_WIN_POS);
      rin_d_reg <= sel_bit(strap_sync, `DCF_RIN_POS);
    end
  end

  // write token passes on when this device fills, read token when it empties
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wxo_pulse_reg <= 1'b0;
      rxo_pulse_reg <= 1'b0;
    end else begin
      wxo_pulse_reg <= casc_mode & wr_go & cnt_at_top(count_next);
      rxo_pulse_reg <= casc_mode & rd_go & cnt_at_zero(count_next);
    end
  end

  // first device takes both tokens once
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      first_seen_reg <= 1'b0;
      wr_token_reg <= 1'b0;
      rd_token_reg <= 1'b0;
    end else begin
      first_seen_reg <= straps_ok;
      if (straps_ok & ~first_seen_reg & first_dev) begin
        wr_token_reg <= 1'b1;
        rd_token_reg <= 1'b1;
      end else begin
        // tokens arrive from the previous device
        if (win_rise) begin
          wr_token_reg <= 1'b1;
        end else if (wr_go & cnt_at_top(count_next)) begin
          wr_token_reg <= 1'b0;
        end
        if (rin_rise) begin
          rd_token_reg <= 1'b1;
        end else if (rd_go & cnt_at_zero(count_next)) begin
          rd_token_reg <= 1'b0;
        end
      end
    end
  end

  // empty follows the read-side output stage
  assign empty_flag_n = buf_out_valid;
  // low when no space
  // count covers the output stages too, so exactly depth words fit
  assign full_flag_n = ~cnt_at_top(count_reg);
  // sync mode flags come from registered state; async almost flags compare count_reg with the offset pins
  assign almost_empty_flag_n = sync_mode_async ? ~ae_level : ~ae_sync_reg;
  assign almost_full_flag_n = sync_mode_async ? ~af_level : ~af_sync_reg;
  // five states decoded from the flag set
  // shared pin: half flag or cascade write out
  assign half_full_flag_n = casc_mode ? wxo_pulse_reg : ~half_level;
  assign cascade_read_out = rxo_pulse_reg;
  assign data_out = q_reg;
  assign data_out_oe = ~output_enable_n;
endmodule

// File: sim/dcf_partner.sv
// producer and consumer standing beside dcf_top, both on clk_sys
// assumes the bench starts and stops each side with wr_run and rd_run
`timescale 1ns/1ps
module dcf_partner (
  input wire logic clk_sys,
  input wire logic wr_run,
  input wire logic rd_run,
  input wire logic full_flag_n,
  output wire logic [17:0] data_in,
  output logic write_enable_n,
  output logic read_enable_n
);
  logic [17:0] nxt;
  initial begin
    nxt = 18'h00000;
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
  end
  // idle bus shows the inverse so a stray store is caught
  assign data_in = write_enable_n ? ~nxt : nxt;
  always @(posedge clk_sys) begin
    // advance only on a taken word
    if (!write_enable_n && full_flag_n) begin
      nxt <= #1 nxt + 18'h00001;
    end
    write_enable_n <= #1 !wr_run;
    read_enable_n <= #1 !rd_run;
  end
endmodule

// File: sim/dcf_top_asserts.sv
// port checker for dcf_top
// assumes one clock domain, attached by the bind at the foot
`timescale 1ns/1ps
module dcf_top_asserts (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  input wire logic depth_cascade_mode,
  input wire logic [17:0] data_out,
  input wire logic data_out_oe,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic half_full_flag_n,
  input wire logic cascade_read_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence wr_into_empty;
    !empty_flag_n && !write_enable_n && full_flag_n;
  endsequence
  sequence word_shows;
    ##[1:4] empty_flag_n;
  endsequence
  oe_drive_a: assert property (data_out_oe == !output_enable_n)
    else $error("output enable not followed");
  read_gate_a: assert property (
    !$stable(data_out) |-> $past(!read_enable_n && empty_flag_n))
    else $error("data_out moved without a taken read");
  empty_exit_a: assert property (wr_into_empty |-> word_shows)
    else $error("written word not readable in time");
  empty_by_read_a: assert property (
    $fell(empty_flag_n) |-> $past(!read_enable_n))
    else $error("empty entered without a read");
  full_by_write_a: assert property (
    $fell(full_flag_n) |-> $past(!write_enable_n) || $past(!write_enable_n, 2))
    else $error("full entered without a write");
  full_half_a: assert property (
    !full_flag_n && !depth_cascade_mode |-> !half_full_flag_n)
    else $error("full but not half full");
  half_nonempty_a: assert property (
    !half_full_flag_n && !depth_cascade_mode |-> empty_flag_n)
    else $error("half full and empty together");
  casc_quiet_a: assert property (
    !depth_cascade_mode |-> !cascade_read_out)
    else $error("cascade output active standalone");
endmodule
bind dcf_top dcf_top_asserts dcf_top_asserts_i (.clk_sys(clk_sys),
  .rstn(rstn), .write_enable_n(write_enable_n),
  .read_enable_n(read_enable_n), .output_enable_n(output_enable_n),
  .depth_cascade_mode(depth_cascade_mode), .data_out(data_out),
  .data_out_oe(data_out_oe), .empty_flag_n(empty_flag_n),
  .full_flag_n(full_flag_n), .half_full_flag_n(half_full_flag_n),
  .cascade_read_out(cascade_read_out));

// File: sim/dual_clock_fifo_with_flags_tb_top.sv
// bench for dcf_top: reset, fill past full, output enable, drain
// assumes dcf_partner supplies the counting word stream
`timescale 1ns/1ps
module dual_clock_fifo_with_flags_tb_top;
  logic clk_sys, rstn, oe_n, fss, wr_run, rd_run, rd_hit, casc;
  logic [12:0] off;
  logic [17:0] rd_exp;
  wire [17:0] din, dout;
  wire wen_n, ren_n, oe, ef, ff, aef, aff, hf, cro;
  int bad_count, total_checks, wr_acc, i;
  dcf_top dcf_top_i (.clk_sys(clk_sys), .rstn(rstn), .data_in(din),
    .write_enable_n(wen_n), .read_enable_n(ren_n),
    .output_enable_n(oe_n), .almost_empty_offset(off),
    .almost_full_offset(off), .flag_sync_select(fss),
    .depth_cascade_mode(casc), .first_load_n(casc),
    .cascade_write_in(casc), .cascade_read_in(casc), .data_out(dout),
    .data_out_oe(oe), .empty_flag_n(ef), .full_flag_n(ff),
    .almost_empty_flag_n(aef), .almost_full_flag_n(aff),
    .half_full_flag_n(hf), .cascade_read_out(cro));
  dcf_partner dcf_partner_i (.clk_sys(clk_sys), .wr_run(wr_run),
    .rd_run(rd_run), .full_flag_n(ff), .data_in(din),
    .write_enable_n(wen_n), .read_enable_n(ren_n));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task check(input string what, input logic [17:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (rstn && !wen_n && ff) wr_acc <= wr_acc + 1;
    rd_hit <= rstn && !ren_n && ef;
  end
  always @(negedge clk_sys) begin
    if (rd_hit) begin
      check("data_out", dout, rd_exp);
      rd_exp = rd_exp + 18'h00001;
    end
  end
  task test_reset;
    check("empty", ef, 0);
    check("full", ff, 1);
    check("half", hf, 1);
    check("casc_out", cro, 0);
    check("data_out", dout, 0);
  endtask
  task test_fill;
    wr_run = 1'b1;
    cyc(300);
    wr_run = 1'b0;
    cyc(4);
    check("full", ff, 0);
    check("half", hf, 0);
    check("almost_full", aff, 0);
    check("empty", ef, 1);
    check("taken", wr_acc[17:0], 18'h00100);
  endtask
  task test_oe;
    oe_n = 1'b1;
    cyc(1);
    check("oe", oe, 0);
    oe_n = 1'b0;
    cyc(1);
    check("oe", oe, 1);
  endtask
  task test_drain;
    rd_run = 1'b1;
    wr_run = 1'b1;
    cyc(40);
    wr_run = 1'b0;
    for (i = 0; i < 400 && ef !== 1'b0; i++) cyc(1);
    cyc(4);
    check("all_read", rd_exp, wr_acc[17:0]);
    check("empty", ef, 0);
    check("full", ff, 1);
    check("almost_empty", aef, 0);
  endtask
  task test_async;
    fss = 1'b1;
    rd_run = 1'b0;
    cyc(4);
    wr_run = 1'b1;
    cyc(9);
    wr_run = 1'b0;
    cyc(6);
    check("almost_empty", aef, 1);
    rd_run = 1'b1;
    cyc(5);
    check("almost_empty", aef, 0);
    cyc(12);
  endtask
  task test_casc;
    casc = 1'b1;
    cyc(4);
    check("half", hf, 0);
    check("casc_out", cro, 0);
  endtask
  initial begin
    {rstn, oe_n, fss, wr_run, rd_run, rd_hit, casc} = 7'h00;
    off = 13'h0007;
    rd_exp = 18'h00000;
    cyc(2);
    rstn = 1'b1;
    cyc(4);
    test_reset;
    test_fill;
    test_oe;
    test_drain;
    test_async;
    test_casc;
    results;
  end
  initial begin
    #50000;
    bad_count++;
    results;
  end
endmodule
